// ==== pkg/rsc_defs.svh ====
// Constants of the redundancy switch controller: command codes,
// strap bit positions, panel entry codes, timing and reset values.
// Assumes inclusion by bare name; definitions only.
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// -------------------------------------------------------------
// Command codes, used as the command port address
// -------------------------------------------------------------
`define CMD_SWMODE 8'h30
`define CMD_STANDBY 8'h31
`define CMD_STATUS 8'h37
`define CMD_CTRL 8'h40
`define CMD_SYS_MUTE 8'h41
`define CMD_UNIT_MUTE 8'h42

// -------------------------------------------------------------
// Command data values
// -------------------------------------------------------------
`define UNIT_ID_SYSTEM 8'h00
`define MODE_AUTO_VAL 8'h01
`define STANDBY_UNIT1 8'h01
`define STANDBY_UNIT2 8'h02

// -------------------------------------------------------------
// Strap bit positions (strap n sits at bit n-1)
// -------------------------------------------------------------
`define ARCH_ON_BIT 6
`define ARCH_OFF_BIT 7
`define ID_FIRST_BIT 0
`define ID_SECOND_BIT 1

// -------------------------------------------------------------
// Panel entry codes
// -------------------------------------------------------------
`define PE_SWMODE 3'h1
`define PE_STANDBY 3'h2
`define PE_SYS_MUTE 3'h3
`define PE_UNIT_MUTE 3'h4
`define PE_CTRL 3'h5

// -------------------------------------------------------------
// Timing and reset values
// -------------------------------------------------------------
`define CLK_KHZ 50000
`define SW_PULSE_MS 100
`define SW_SETTLE_MS 100
`define RST_STANDBY2 1'b1

`endif

// ==== pkg/rsc_pkg.sv ====
// Types of the redundancy switch controller.
// Assumes nothing beyond a SystemVerilog compiler.
package rsc_pkg;

   // ----------------------------------------------------------
   // Switch drive sequencer states
   // ----------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DRIVE = 3'b010,
      ST_SETTLE = 3'b100
   } sw_state_t;

   // ----------------------------------------------------------
   // Inter-unit link, one direction
   // ----------------------------------------------------------
   typedef struct packed {
      logic fault;
      logic mode_auto;
      logic standby2;
      logic cfg_tgl;
      logic sys_mute;
      logic mute_tgl;
   } link_t;

   // ----------------------------------------------------------
   // Status display fields
   // ----------------------------------------------------------
   typedef struct packed {
      logic local_control_indicator;
      logic remote_control_indicator;
      logic manual_mode_indicator;
      logic online;
      logic summary_fault_indicator;
      logic sys_mute;
      logic [7:0] atten;
   } status_t;

   // ----------------------------------------------------------
   // Status word read at the status command
   // ----------------------------------------------------------
   typedef struct packed {
      logic [3:0] zero;
      logic busy;
      logic at_pos2;
      logic unit2;
      logic redundant;
      logic mute;
      logic sys_mute;
      logic sw_fault;
      logic summary;
      logic me_standby;
      logic standby2;
      logic mode_auto;
      logic remote;
   } stat_word_t;

   // ----------------------------------------------------------
   // Asynchronous inputs, sampled as one vector
   // ----------------------------------------------------------
   typedef struct packed {
      logic [7:0] arch;
      logic [1:0] id;
      logic plus;
      logic minus;
      logic [2:0] entry;
      logic fault;
      logic at_pos1;
      logic at_pos2;
      link_t link;
   } pins_t;

   // ----------------------------------------------------------
   // Whole state of the controller
   // ----------------------------------------------------------
   typedef struct packed {
      pins_t sync1;
      pins_t sync2;
      logic plus_q;
      logic minus_q;
      logic cfg_q;
      logic mute_q;
      logic remote;
      logic mode_auto;
      logic standby2;
      logic cfg_tgl;
      logic sys_mute;
      logic mute;
      logic mute_tgl;
      logic cmd_pos2;
      logic sw_fault;
      sw_state_t fsm;
      logic [23:0] cnt;
      logic ack;
      logic nak;
      logic drv1;
      logic drv2;
      logic common;
      logic par_pos1;
      logic [15:0] rdata;
      status_t status;
      link_t link;
   } state_t;

endpackage

// ==== src/redundancy_switch_control.sv ====
// Controller of one unit of a 1:1 redundant amplifier pair.
// Assumes a 50 MHz clock, pins synchronised here, a command port on
// the same clock, and a peer unit running this same logic.
//
// What this block does
// - Keep switch common energised and pulse one position drive line.
// - After each drive pulse read back switch position and confirm it.
// - Redundant operation only with architecture strap 7 on, strap 8 off.
// - Identity straps: first on second off unit 1, reverse unit 2.
// - Auto mode: on-line fault switches the healthy standby on-line.
// - Manual mode: no switchover, summary fault raised, wait for selection.
// - Switching-mode entry: plus or minus key toggles auto and manual.
// - Standby entry: plus or minus key toggles the standby unit.
// - Standby selection only accepted in manual mode; refused in auto.
// - System mute or unmute changes both units together.
// - Unit mute or unmute changes only the receiving unit.
// - Mute indicator shows this unit's own mute state.
// - Status shows control, mode, role, and fault only when present.
// - Second line shows attenuation and system mute state.
// - Parallel port shows switch position only; second switch unused.
// - Serial commands act only in remote mode; remote set and status read any time.
// - All panel functions also available over the serial port.
// - Automatic switchover completes in nominally 200 ms.
// - Failed switching raises a switch fault as summary fault.
// - Command 0x30: unit id zero, mode 0 manual, 1 auto.
// - Command 0x31: unit id zero, standby unit 1 or 2.
`timescale 1ns/100ps
`include "rsc_defs.svh"

module redundancy_switch_control #(
   parameter int P_PULSE_CYC = `SW_PULSE_MS * `CLK_KHZ,
   parameter int P_SETTLE_CYC = `SW_SETTLE_MS * `CLK_KHZ
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // Configuration straps
   input wire logic [7:0] i_architecture_strap_bank,
   input wire logic [1:0] i_unit_identity_strap_bank,
   // Local panel
   input wire logic i_key_plus,
   input wire logic i_key_minus,
   input wire logic [2:0] i_panel_entry,
   // Own amplifier
   input wire logic i_unit_fault,
   input wire logic [7:0] i_atten,
   // Serial command port
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   output logic o_cmd_ack,
   output logic o_cmd_nak,
   // Inter-unit link
   input rsc_pkg::link_t i_link,
   output rsc_pkg::link_t o_link,
   // RF switch
   input wire logic i_sw_at_pos1,
   input wire logic i_sw_at_pos2,
   output logic o_sw_common_en,
   output logic o_sw_pos1_drive,
   output logic o_sw_pos2_drive,
   // Display, indicators and parallel port
   output rsc_pkg::status_t o_status,
   output logic o_mute,
   output logic o_par_sw_pos1
);
   import rsc_pkg::*;

   // ----------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------
   logic [1:0] rst_q_r;
   logic rst_n_s;
   state_t s_r;
   state_t s_nxt;
   pins_t pins_in;
   pins_t p;
   logic redund;
   logic unit1;
   logic unit2;
   logic me_sb;
   logic online_f;
   logic sb_f;
   logic key_ev;
   logic cfg_ev;
   logic mute_ev;
   logic auto_sw;
   logic pos_ok;
   logic drive_end;
   logic settle_end;
   stat_word_t stat_w;

   // ----------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------

   // Two-stage release of the asynchronous reset
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_q_r <= 2'b00;
      end else begin
         rst_q_r <= {rst_q_r[0], 1'b1};
      end
   end
   assign rst_n_s = rst_q_r[1];

   // ----------------------------------------------------------
   // Decode of current state
   // ----------------------------------------------------------

   // Pins gathered for the two-flop synchroniser
   assign pins_in = {i_architecture_strap_bank, i_unit_identity_strap_bank, i_key_plus, i_key_minus,
                     i_panel_entry, i_unit_fault, i_sw_at_pos1, i_sw_at_pos2, i_link};
   assign p = s_r.sync2;

   // Architecture and identity straps
   assign redund = p.arch[`ARCH_ON_BIT] & ~p.arch[`ARCH_OFF_BIT];
   assign unit1 = p.id[`ID_FIRST_BIT] & ~p.id[`ID_SECOND_BIT];
   assign unit2 = ~p.id[`ID_FIRST_BIT] & p.id[`ID_SECOND_BIT];

   // Role: the unit not named standby is on-line
   assign me_sb = s_r.standby2 ? unit2 : unit1;
   assign online_f = me_sb ? p.link.fault : p.fault;
   assign sb_f = me_sb ? p.fault : p.link.fault;

   // Key presses and peer update events
   assign key_ev = (p.plus & ~s_r.plus_q) | (p.minus & ~s_r.minus_q);
   assign cfg_ev = p.link.cfg_tgl ^ s_r.cfg_q;
   assign mute_ev = p.link.mute_tgl ^ s_r.mute_q;

   // Automatic switchover trigger
   assign auto_sw = redund & s_r.mode_auto & (s_r.fsm == ST_IDLE) & online_f & ~sb_f;

   // Position read-back against the commanded position
   assign pos_ok = s_r.cmd_pos2 ? (p.at_pos2 & ~p.at_pos1) : (p.at_pos1 & ~p.at_pos2);
   assign drive_end = s_r.cnt == 24'(P_PULSE_CYC - 1);
   assign settle_end = s_r.cnt == 24'(P_SETTLE_CYC - 1);

   // Status word for the status command
   always_comb begin
      stat_w = '0;
      stat_w.busy = s_r.fsm != ST_IDLE;
      stat_w.at_pos2 = p.at_pos2;
      stat_w.unit2 = unit2;
      stat_w.redundant = redund;
      stat_w.mute = s_r.mute;
      stat_w.sys_mute = s_r.sys_mute;
      stat_w.sw_fault = s_r.sw_fault;
      stat_w.summary = s_r.status.summary_fault_indicator;
      stat_w.me_standby = me_sb;
      stat_w.standby2 = s_r.standby2;
      stat_w.mode_auto = s_r.mode_auto;
      stat_w.remote = s_r.remote;
   end

   // ----------------------------------------------------------
   // Next state
   // ----------------------------------------------------------

   // Whole controller in one combinational pass
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.nak = 1'b0;
      s_nxt.rdata = '0;
      s_nxt.sync1 = pins_in;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.plus_q = p.plus;
      s_nxt.minus_q = p.minus;
      s_nxt.cfg_q = p.link.cfg_tgl;
      s_nxt.mute_q = p.link.mute_tgl;

      // Adopt settings announced by the peer
      if (cfg_ev) begin
         s_nxt.mode_auto = p.link.mode_auto;
         s_nxt.standby2 = p.link.standby2;
      end
      if (mute_ev) begin
         s_nxt.sys_mute = p.link.sys_mute;
         s_nxt.mute = p.link.sys_mute;
      end

      // Swap roles when the on-line unit fails
      if (auto_sw) begin
         s_nxt.standby2 = ~s_r.standby2;
         s_nxt.cfg_tgl = ~s_r.cfg_tgl;
      end

      // Local panel keys
      if (key_ev) begin
         case (p.entry)
            `PE_SWMODE: begin
               s_nxt.mode_auto = ~s_r.mode_auto;
               s_nxt.cfg_tgl = ~s_r.cfg_tgl;
            end
            `PE_STANDBY: begin
               if (!s_r.mode_auto) begin
                  s_nxt.standby2 = ~s_r.standby2;
                  s_nxt.cfg_tgl = ~s_r.cfg_tgl;
               end
            end
            `PE_SYS_MUTE: begin
               s_nxt.sys_mute = ~s_r.sys_mute;
               s_nxt.mute = ~s_r.sys_mute;
               s_nxt.mute_tgl = ~s_r.mute_tgl;
            end
            `PE_UNIT_MUTE: begin
               s_nxt.mute = ~s_r.mute;
            end
            `PE_CTRL: begin
               s_nxt.remote = ~s_r.remote;
            end
            default: begin
               s_nxt.remote = s_r.remote;
            end
         endcase
      end

      // Serial commands, gated by remote mode
      if (i_wr) begin
         if (i_addr == `CMD_CTRL) begin
            s_nxt.remote = i_wdata[0];
            s_nxt.ack = 1'b1;
         end else if (!s_r.remote) begin
            s_nxt.nak = 1'b1;
         end else begin
            case (i_addr)
               `CMD_SWMODE: begin
                  if (i_wdata[15:8] == `UNIT_ID_SYSTEM && i_wdata[7:0] <= `MODE_AUTO_VAL) begin
                     s_nxt.mode_auto = i_wdata[0];
                     s_nxt.cfg_tgl = ~s_r.cfg_tgl;
                     s_nxt.ack = 1'b1;
                  end else begin
                     s_nxt.nak = 1'b1;
                  end
               end
               `CMD_STANDBY: begin
                  if (i_wdata[15:8] == `UNIT_ID_SYSTEM && !s_r.mode_auto &&
                      (i_wdata[7:0] == `STANDBY_UNIT1 || i_wdata[7:0] == `STANDBY_UNIT2)) begin
                     s_nxt.standby2 = i_wdata[7:0] == `STANDBY_UNIT2;
                     s_nxt.cfg_tgl = ~s_r.cfg_tgl;
                     s_nxt.ack = 1'b1;
                  end else begin
                     s_nxt.nak = 1'b1;
                  end
               end
               `CMD_SYS_MUTE: begin
                  s_nxt.sys_mute = i_wdata[0];
                  s_nxt.mute = i_wdata[0];
                  s_nxt.mute_tgl = ~s_r.mute_tgl;
                  s_nxt.ack = 1'b1;
               end
               `CMD_UNIT_MUTE: begin
                  s_nxt.mute = i_wdata[0];
                  s_nxt.ack = 1'b1;
               end
               default: begin
                  s_nxt.nak = 1'b1;
               end
            endcase
         end
      end

      // Status read, answered in the next cycle only
      if (i_rd && i_addr == `CMD_STATUS) begin
         s_nxt.rdata = stat_w;
      end

      // Switch drive sequencer: pulse, settle, verify
      s_nxt.cnt = s_r.cnt + 24'h000001;
      case (s_r.fsm)
         ST_IDLE: begin
            s_nxt.cnt = '0;
            if (s_r.cmd_pos2 == s_r.standby2) begin
               s_nxt.fsm = ST_DRIVE;
               s_nxt.cmd_pos2 = ~s_r.standby2;
            end
         end
         ST_DRIVE: begin
            if (drive_end) begin
               s_nxt.fsm = ST_SETTLE;
               s_nxt.cnt = '0;
            end
         end
         ST_SETTLE: begin
            if (settle_end) begin
               s_nxt.fsm = ST_IDLE;
               s_nxt.sw_fault = ~pos_ok;
            end
         end
         default: begin
            s_nxt.fsm = ST_IDLE;
         end
      endcase
      if (!redund) begin
         s_nxt.fsm = ST_IDLE;
         s_nxt.cnt = '0;
      end

      // Switch lines, one position at a time
      s_nxt.common = redund;
      s_nxt.drv1 = (s_nxt.fsm == ST_DRIVE) & ~s_nxt.cmd_pos2;
      s_nxt.drv2 = (s_nxt.fsm == ST_DRIVE) & s_nxt.cmd_pos2;
      s_nxt.par_pos1 = p.at_pos1;

      // Display fields and indicators
      s_nxt.status.local_control_indicator = ~s_nxt.remote;
      s_nxt.status.remote_control_indicator = s_nxt.remote;
      s_nxt.status.manual_mode_indicator = ~s_nxt.mode_auto;
      s_nxt.status.online = ~me_sb;
      // Summary fault: own, switch, or failed on-line unit
      s_nxt.status.summary_fault_indicator = p.fault | s_nxt.sw_fault | (redund & online_f);
      s_nxt.status.sys_mute = s_nxt.sys_mute;
      s_nxt.status.atten = i_atten;

      // Announcements to the peer
      s_nxt.link.fault = p.fault;
      s_nxt.link.mode_auto = s_nxt.mode_auto;
      s_nxt.link.standby2 = s_nxt.standby2;
      s_nxt.link.cfg_tgl = s_nxt.cfg_tgl;
      s_nxt.link.sys_mute = s_nxt.sys_mute;
      s_nxt.link.mute_tgl = s_nxt.mute_tgl;
   end

   // ----------------------------------------------------------
   // State register
   // ----------------------------------------------------------

   // All state held in one register
   always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
      if (!rst_n_s) begin
         s_r <= '0;
         s_r.fsm <= ST_IDLE;
         s_r.standby2 <= `RST_STANDBY2;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------

   // Every output straight from the register
   assign o_rdata = s_r.rdata;
   assign o_cmd_ack = s_r.ack;
   assign o_cmd_nak = s_r.nak;
   assign o_link = s_r.link;
   assign o_sw_common_en = s_r.common;
   assign o_sw_pos1_drive = s_r.drv1;
   assign o_sw_pos2_drive = s_r.drv2;
   assign o_status = s_r.status;
   assign o_mute = s_r.mute;
   assign o_par_sw_pos1 = s_r.par_pos1;

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!rst_n_s);

   // One position line at a time
   a_drive_exclusive: assert property (!(o_sw_pos1_drive && o_sw_pos2_drive))
      else $error("both switch position lines driven");

   // Drive only with the common energised
   a_drive_common: assert property ((o_sw_pos1_drive || o_sw_pos2_drive) |-> o_sw_common_en)
      else $error("switch drive without common");

   // Drive pulse stays within its count
   a_pulse_bounded: assert property ((s_r.fsm == ST_DRIVE) |-> s_r.cnt < 24'(P_PULSE_CYC))
      else $error("switch drive pulse too long");

   // Verify outcome matches read-back
   a_verify_fault: assert property ((s_r.fsm == ST_SETTLE && settle_end && redund) |=>
      s_r.sw_fault == !$past(pos_ok))
      else $error("switch verify result wrong");

   // Switch fault reaches the summary fault
   a_fault_summary: assert property ((s_r.sw_fault && s_r.fsm == ST_IDLE) |=> o_status.summary_fault_indicator)
      else $error("switch fault not in summary");

   // Sequence ends right after settling
   a_switch_time: assert property ((s_r.fsm == ST_SETTLE && settle_end) |=> s_r.fsm == ST_IDLE)
      else $error("switchover not finished in time");

   // No drive outside redundant architecture
   a_arch_gate: assert property (!redund |=> !o_sw_pos1_drive && !o_sw_pos2_drive)
      else $error("switch driven outside redundant mode");

   // Auto mode swaps roles on on-line fault
   a_auto_swap: assert property ((auto_sw && !i_wr && !key_ev && !cfg_ev) |=>
      s_r.standby2 != $past(s_r.standby2))
      else $error("auto switchover missing");

   // Manual mode keeps roles without a selection
   a_manual_hold: assert property ((redund && !s_r.mode_auto && !i_wr && !key_ev && !cfg_ev) |=>
      $stable(s_r.standby2))
      else $error("manual mode switched by itself");

   // Standby selection refused in auto
   a_standby_refused: assert property ((s_r.mode_auto && i_wr && i_addr == `CMD_STANDBY && !auto_sw && !cfg_ev) |=>
      o_cmd_nak && $stable(s_r.standby2))
      else $error("standby selection taken in auto");

   // Local mode refuses serial commands
   a_remote_gate: assert property ((!s_r.remote && i_wr && i_addr != `CMD_CTRL) |=> o_cmd_nak && !o_cmd_ack)
      else $error("serial command taken in local mode");

   // System mute reaches own state and the peer
   a_sys_mute: assert property ((s_r.remote && i_wr && i_addr == `CMD_SYS_MUTE) |=>
      (o_mute == $past(i_wdata[0]) && o_link.mute_tgl != $past(o_link.mute_tgl)))
      else $error("system mute not applied to pair");
endmodule

// ==== tb/switch_model.sv ====
// Two-position RF transfer switch driven by the controller.
// Assumes a drive line high means that position is pulled to ground.
`timescale 1ns/100ps

module switch_model (
   // Controller side
   input wire logic i_clk,
   input wire logic i_common,
   input wire logic i_drv1,
   input wire logic i_drv2,
   // Stuck switch for failure tests
   input wire logic i_stuck,
   // Position indications
   output logic o_at_pos1,
   output logic o_at_pos2
);
   logic pos2_r = 1'b0;

   // Moves only with common energised and one line pulled
   always @(posedge i_clk) begin
      if (i_common && !i_stuck && i_drv1 && !i_drv2) begin
         pos2_r <= 1'b0;
      end
      if (i_common && !i_stuck && i_drv2 && !i_drv1) begin
         pos2_r <= 1'b1;
      end
   end

   // One indication high at a time
   assign o_at_pos1 = !pos2_r;
   assign o_at_pos2 = pos2_r;
endmodule

// ==== tb/test_redundancy_switch_control.sv ====
// Self-checking bench of one controller as unit 1 of a pair.
// Assumes short pulse and settle counts of 8 cycles each.
`timescale 1ns/100ps

module test_redundancy_switch_control;
   import rsc_pkg::*;
   logic clk, rst_n, kp, km, ufault, wr, rd, stuck, ack, nak, com, d1, d2, at1, at2, mute, par1;
   logic [2:0] entry;
   logic [7:0] addr;
   logic [15:0] wdata, rdata;
   link_t lnk_in, lnk_out;
   status_t st;
   int errors = 0;
   int compares = 0;

   redundancy_switch_control #(.P_PULSE_CYC(8), .P_SETTLE_CYC(8)) uut (
      .i_clk_sys(clk), .i_reset_n(rst_n), .i_architecture_strap_bank(8'h40),
      .i_unit_identity_strap_bank(2'h1), .i_key_plus(kp), .i_key_minus(km),
      .i_panel_entry(entry), .i_unit_fault(ufault), .i_atten(8'h5A), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_cmd_ack(ack),
      .o_cmd_nak(nak), .i_link(lnk_in), .o_link(lnk_out), .i_sw_at_pos1(at1),
      .i_sw_at_pos2(at2), .o_sw_common_en(com), .o_sw_pos1_drive(d1),
      .o_sw_pos2_drive(d2), .o_status(st), .o_mute(mute), .o_par_sw_pos1(par1));

   switch_model sw (.i_clk(clk), .i_common(com), .i_drv1(d1), .i_drv2(d2),
      .i_stuck(stuck), .o_at_pos1(at1), .o_at_pos2(at2));

   // Clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Verdict and end of run
   task automatic stop_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   // One command write, answer judged
   task automatic cmd(input logic [7:0] a, input logic [15:0] d, input logic ok);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
      chk("ack", {15'h0, ok}, {15'h0, ack});
      chk("nak", {15'h0, !ok}, {15'h0, nak});
   endtask

   // One status read, word taken in the cycle after the strobe
   task automatic rd_stat(input logic [15:0] e);
      @(posedge clk);
      addr <= `CMD_STATUS;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("stat", e, rdata);
      @(posedge clk);
      #1;
      chk("stat_gone", 16'h0, rdata);
   endtask

   // Waits for a drive pulse, measures it and the other line
   task automatic pulse(input logic two, input int exp);
      int n;
      int len;
      int oth;
      n = 0;
      len = 0;
      oth = 0;
      while ((two ? d2 : d1) !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      while ((two ? d2 : d1) === 1'b1 && len < 40) begin
         if ((two ? d1 : d2) !== 1'b0) oth++;
         @(posedge clk);
         #1;
         len++;
      end
      chk("pulse", exp[15:0], len[15:0]);
      chk("other", 16'h0, oth[15:0]);
      repeat (12) @(posedge clk);
      #1;
   endtask

   // Panel key press
   task automatic key(input logic [2:0] e, input logic minus);
      @(posedge clk);
      entry <= e;
      kp <= !minus;
      km <= minus;
      repeat (6) @(posedge clk);
      kp <= 1'b0;
      km <= 1'b0;
      repeat (6) @(posedge clk);
      entry <= 3'h0;
      #1;
   endtask

   task automatic t_reset;
      chk("idle", 16'h003A, {10'h0, st.local_control_indicator, st.manual_mode_indicator, st.online,
         st.summary_fault_indicator, com, mute});
   endtask

   task automatic t_remote;
      cmd(`CMD_SYS_MUTE, 16'h1, 1'b0);
      cmd(`CMD_CTRL, 16'h1, 1'b1);
      chk("rem", 16'h1, {15'h0, st.remote_control_indicator});
   endtask

   task automatic t_select;
      cmd(`CMD_STANDBY, 16'h1, 1'b1);
      pulse(1'b1, 8);
      chk("sel", 16'h0, {13'h0, st.online, par1, st.summary_fault_indicator});
   endtask

   task automatic t_auto;
      cmd(`CMD_SWMODE, 16'h1, 1'b1);
      cmd(`CMD_STANDBY, 16'h2, 1'b0);
      cmd(`CMD_SWMODE, 16'h0101, 1'b0);
      lnk_in.fault <= 1'b1;
      pulse(1'b0, 8);
      chk("auto", 16'h3, {14'h0, st.online, par1});
      lnk_in.fault <= 1'b0;
   endtask

   task automatic t_manual_fault;
      cmd(`CMD_SWMODE, 16'h0, 1'b1);
      ufault <= 1'b1;
      pulse(1'b1, 0);
      chk("man", 16'h3, {14'h0, st.summary_fault_indicator, st.online});
      ufault <= 1'b0;
   endtask

   task automatic t_fail;
      stuck <= 1'b1;
      cmd(`CMD_STANDBY, 16'h1, 1'b1);
      pulse(1'b1, 8);
      chk("swf", 16'h1, {15'h0, st.summary_fault_indicator});
      stuck <= 1'b0;
      cmd(`CMD_STANDBY, 16'h2, 1'b1);
      pulse(1'b0, 8);
      chk("swok", 16'h0, {15'h0, st.summary_fault_indicator});
   endtask

   task automatic t_mute;
      logic tg;
      tg = lnk_out.mute_tgl;
      cmd(`CMD_SYS_MUTE, 16'h1, 1'b1);
      chk("smute", {14'h0, !tg, 1'b1}, {14'h0, lnk_out.mute_tgl, st.sys_mute});
      cmd(`CMD_UNIT_MUTE, 16'h0, 1'b1);
      chk("umute", 16'h015A, {7'h0, st.sys_mute, st.atten});
      chk("led", 16'h0, {15'h0, mute});
      rd_stat(16'h0145);
      chk("link", 16'h3, {13'h0, lnk_out.mode_auto, lnk_out.standby2, lnk_out.sys_mute});
   endtask

   task automatic t_panel;
      key(`PE_STANDBY, 1'b0);
      chk("sby", 16'h0, {15'h0, st.online});
      key(`PE_SWMODE, 1'b1);
      chk("mode", 16'h0, {15'h0, st.manual_mode_indicator});
      key(`PE_UNIT_MUTE, 1'b1);
      chk("pmute", 16'h3, {14'h0, mute, st.sys_mute});
      key(`PE_SYS_MUTE, 1'b0);
      chk("psmute", 16'h0, {14'h0, mute, st.sys_mute});
      key(`PE_CTRL, 1'b1);
      chk("loc", 16'h1, {15'h0, st.local_control_indicator});
   endtask

   // Watchdog
   initial begin
      #200us;
      errors++;
      stop_test();
   end

   // Main sequence
   initial begin
      {rst_n, kp, km, ufault, wr, rd, stuck, entry, addr, wdata} = '0;
      lnk_in = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      t_reset();
      t_remote();
      t_select();
      t_auto();
      t_manual_fault();
      t_fail();
      t_mute();
      t_panel();
      stop_test();
   end
endmodule
